// ==== src/strap_pkg.sv ====
// Package for the strap latch: control bit positions, codes, defaults.
// Assumes a single core clock domain; no bus, bits are plain ports.
package strap_pkg;

   // ------------------------------------------------------------
   // Management address
   // ------------------------------------------------------------
   localparam int          MGMT_ADDR_W      = 5;
   localparam int          MGMT_STRAP_W     = 3;
   localparam logic [1:0]  MGMT_ADDR_HI_RST = 2'h0;
   localparam logic [2:0]  MGMT_ADDR_DFLT   = 3'h1;

   // ------------------------------------------------------------
   // Control register 0h bit positions
   // ------------------------------------------------------------
   localparam int          CTRL_W           = 16;
   localparam int          CTRL_DUPLEX_BIT  = 8;
   localparam int          CTRL_ISO_BIT     = 10;
   localparam int          CTRL_ANEG_BIT    = 12;
   localparam int          CTRL_SPEED_BIT   = 13;
   localparam int          BCAST_OFF_BIT    = 9;  // In register 16h

   // ------------------------------------------------------------
   // Interface mode strap codes
   // ------------------------------------------------------------
   localparam logic [2:0]  IFMODE_MII       = 3'h0;
   localparam logic [2:0]  IFMODE_B2B       = 3'h6;

   // ------------------------------------------------------------
   // Strap defaults (internal pull levels)
   // ------------------------------------------------------------
   localparam logic        ISO_DFLT         = 1'b0;
   localparam logic        SPEED_DFLT       = 1'b1;
   localparam logic        DUPLEX_DFLT      = 1'b1;
   localparam logic        ANEG_DFLT        = 1'b1;
   localparam logic        BCAST_OFF_DFLT   = 1'b0;
   localparam logic        NAND_N_DFLT      = 1'b1;
   localparam logic [2:0]  IFMODE_DFLT      = 3'h0;

   // Core clock 25 MHz; no timed figure in this block
   localparam int          CLK_PERIOD_NS    = 40;

   typedef enum logic [1:0] {
      IFM_MII,
      IFM_B2B,
      IFM_RSVD
   } ifmode_t;

endpackage : strap_pkg

// ==== src/strap_sync_if.sv ====
// Interface carrying raw strap pin levels to the synchroniser and back.
// Assumes both ends sit on core_clk.
`timescale 1ns/1ns
interface strap_sync_if #(parameter int W = 12);
   logic [W-1:0] raw;
   logic [W-1:0] synced;
   modport src  (output raw, input synced);
   modport sync (input raw, output synced);
endinterface : strap_sync_if

// ==== src/strap_sync.sv ====
// Two flip-flop synchroniser for a bus of independent strap levels.
// Assumes each bit is a quasi-static level, so no bus coherence needed.
`timescale 1ns/1ns
module strap_sync
(
   input  wire logic  core_clk,
   input  wire logic  srst,
   strap_sync_if.sync sif
);
   localparam int W = $bits(sif.raw);

   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // ------------------------------------------------------------
   // Synchroniser stages
   // ------------------------------------------------------------
   // First stage feeds only the second; reset to zero is harmless
   // because the strap capture waits for the third edge after reset release
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         meta_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         meta_q <= sif.raw;
         sync_q <= meta_q;
      end
   end

   assign sif.synced = sync_q;

endmodule : strap_sync

// ==== src/phy_strap_latch.sv ====
// Strap latch: captures configuration pin levels when reset releases.
// Assumes srst is the chip reset already synchronous to core_clk, and
// strap pins are asynchronous levels passed through two flip-flops.
`timescale 1ns/1ns

// Overview of operation
// - Sample straps at reset release, use them
// - Low three address bits from straps
// - Upper two address bits fixed at zero
// - Address zero broadcast unless disabled
// - Decode interface mode; flag reserved codes
// - Isolate strap loads control bit 10
// - Speed strap loads bit 13, advertisement
// - Duplex strap loads bit 8
// - Autoneg strap loads bit 12
// - NAND tree only when strap low
// - Pins input until straps captured, output after
module phy_strap_latch
(
   input  wire logic                    core_clk,
   input  wire logic                    srst,
   // Strap pin levels, asynchronous
   input  wire logic [2:0]              mgmt_addr_strap,
   input  wire logic [2:0]              ifmode_strap,
   input  wire logic                    iso_strap,
   input  wire logic                    speed_strap,
   input  wire logic                    duplex_strap,
   input  wire logic                    autoneg_en_strap,
   input  wire logic                    bcast_disable_strap,
   input  wire logic                    nand_tree_n_strap,
   // Software overrides from the register block
   input  wire logic                    ctrl_wr,
   input  wire logic [15:0]             ctrl_wdata,
   input  wire logic                    bcast_off_wr,
   input  wire logic                    bcast_off_wdata,
   input  wire logic                    adv_speed_wr,
   input  wire logic                    adv_speed_wdata,
   // Normal-function pin drive after reset
   input  wire logic [11:0]             func_pin_out,
   output logic [11:0]                  strap_pin_out,
   output logic [11:0]                  strap_pin_oe,
   // Configuration results
   output logic [4:0]                   mgmt_addr_value,
   output logic                         bcast_addr_en,
   output strap_pkg::ifmode_t           ifmode,
   output logic                         ifmode_rsvd,
   output logic [15:0]                  ctrl_reg,
   output logic                         adv_speed_100,
   output logic                         nand_tree_en,
   output logic                         straps_valid
);

   // Twelve strap levels: address 3, mode 3, six single bits
   localparam int NSTRAP = 12;

   // Decoded mode values, named for the selection further down
   localparam strap_pkg::ifmode_t IFMC_MII  = strap_pkg::IFM_MII;
   localparam strap_pkg::ifmode_t IFMC_B2B  = strap_pkg::IFM_B2B;
   localparam strap_pkg::ifmode_t IFMC_RSVD = strap_pkg::IFM_RSVD;

   strap_sync_if #(.W(NSTRAP)) sif ();

   logic         rst_d1_q;
   logic         capture;
   logic [2:0]   addr_q;
   logic [2:0]   mode_q;
   logic         bcast_off_q;
   logic         nand_n_q;
   logic         valid_q;
   logic [15:0]  ctrl_q;
   logic         adv_q;
   logic [2:0]   s_addr;
   logic [2:0]   s_mode;
   logic         s_iso;
   logic         s_speed;
   logic         s_duplex;
   logic         s_aneg;
   logic         s_bcast;
   logic         s_nand_n;
   logic [15:0]  ctrl_strap;
   logic         mode_is_mii;
   logic         mode_is_b2b;

   // ------------------------------------------------------------
   // Pin synchronisation
   // ------------------------------------------------------------
   assign sif.raw = {mgmt_addr_strap, ifmode_strap, iso_strap,
                     speed_strap, duplex_strap, autoneg_en_strap,
                     bcast_disable_strap, nand_tree_n_strap};

   strap_sync u_sync
   (
      .core_clk (core_clk),
      .srst     (srst),
      .sif      (sif.sync)
   );

   // Field split of the synchronised strap bus
   // Bit order matches the concatenation above, address on top
   assign s_addr   = sif.synced[11:9];
   assign s_mode   = sif.synced[8:6];
   assign s_iso    = sif.synced[5];
   assign s_speed  = sif.synced[4];
   assign s_duplex = sif.synced[3];
   assign s_aneg   = sif.synced[2];
   assign s_bcast  = sif.synced[1];
   assign s_nand_n = sif.synced[0];

   // ------------------------------------------------------------
   // Reset release detection
   // ------------------------------------------------------------
   // Synchroniser is flushed by srst, so right after the release it
   // still holds zeros: pins seen at the first low edge reach the
   // second stage only after the second edge. Capture fires on the
   // third edge; one edge sooner it would latch the flushed zeros.
   logic rst_d2_q;
   logic rst_d3_q;

   always_ff @(posedge core_clk)
   begin
      rst_d1_q <= srst;
      rst_d2_q <= rst_d1_q;
      rst_d3_q <= rst_d2_q;
   end

   // One-cycle strobe, high between the second and third edges
   assign capture = !srst && !rst_d1_q && !rst_d2_q && rst_d3_q;

   // Control register image built from strap levels
   always_comb
   begin
      ctrl_strap = 16'h0000;
      ctrl_strap[strap_pkg::CTRL_ISO_BIT]    = s_iso;
      ctrl_strap[strap_pkg::CTRL_SPEED_BIT]  = s_speed;
      ctrl_strap[strap_pkg::CTRL_DUPLEX_BIT] = s_duplex;
      ctrl_strap[strap_pkg::CTRL_ANEG_BIT]   = s_aneg;
   end

   // ------------------------------------------------------------
   // Capture and hold
   // ------------------------------------------------------------
   // Defaults apply during reset and until the capture edge;
   // afterwards values only change by software writes.
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         addr_q      <= strap_pkg::MGMT_ADDR_DFLT;
         mode_q      <= strap_pkg::IFMODE_DFLT;
         bcast_off_q <= strap_pkg::BCAST_OFF_DFLT;
         nand_n_q    <= strap_pkg::NAND_N_DFLT;
         valid_q     <= 1'b0;
      end
      else if (capture)
      begin
         addr_q      <= s_addr;
         mode_q      <= s_mode;
         bcast_off_q <= s_bcast;
         nand_n_q    <= s_nand_n;
         valid_q     <= 1'b1;
      end
      else if (bcast_off_wr && valid_q)
      begin
         bcast_off_q <= bcast_off_wdata;
      end
   end

   // Control bits: strap first, then software owns them
   // Capture and write never meet: valid_q is low on the capture edge
   always_ff @(posedge core_clk)
   begin
      if (srst)
      begin
         ctrl_q <= 16'h0000;
         ctrl_q[strap_pkg::CTRL_SPEED_BIT]  <= strap_pkg::SPEED_DFLT;
         ctrl_q[strap_pkg::CTRL_DUPLEX_BIT] <= strap_pkg::DUPLEX_DFLT;
         ctrl_q[strap_pkg::CTRL_ANEG_BIT]   <= strap_pkg::ANEG_DFLT;
         ctrl_q[strap_pkg::CTRL_ISO_BIT]    <= strap_pkg::ISO_DFLT;
         adv_q  <= strap_pkg::SPEED_DFLT;
      end
      else if (capture)
      begin
         ctrl_q <= ctrl_strap;
         adv_q  <= s_speed;
      end
      else
      begin
         if (ctrl_wr && valid_q)
            ctrl_q <= ctrl_wdata;
         if (adv_speed_wr && valid_q)
            adv_q <= adv_speed_wdata;
      end
   end

   // ------------------------------------------------------------
   // Decoded outputs
   // ------------------------------------------------------------
   // Upper address bits carry no strap in this package variant
   assign mgmt_addr_value = {strap_pkg::MGMT_ADDR_HI_RST, addr_q};
   // Zero answers as broadcast unless turned off by strap or write
   assign bcast_addr_en   = !bcast_off_q;
   // Only two codes are defined; every other code reads as reserved
   assign mode_is_mii     = (mode_q == strap_pkg::IFMODE_MII);
   assign mode_is_b2b     = (mode_q == strap_pkg::IFMODE_B2B);
   assign ifmode          = mode_is_mii ? IFMC_MII
                          : mode_is_b2b ? IFMC_B2B
                          : IFMC_RSVD;
   assign ifmode_rsvd     = (ifmode == strap_pkg::IFM_RSVD);
   assign ctrl_reg        = ctrl_q;
   assign adv_speed_100   = adv_q;
   // Active-low strap: test mode only on a captured low level
   assign nand_tree_en    = valid_q && !nand_n_q;
   assign straps_valid    = valid_q;

   // ------------------------------------------------------------
   // Pin direction
   // ------------------------------------------------------------
   // Held as inputs until straps are taken, so the board pulls
   // are never fought by our own drivers.
   // Limitation: one enable for all twelve pins, no per-pin control.
   assign strap_pin_oe  = valid_q ? 12'hfff : 12'h000;
   assign strap_pin_out = valid_q ? func_pin_out : 12'h000;

endmodule : phy_strap_latch

// ==== dv/phy_strap_latch_properties.sv ====
// Checker for the strap latch: capture moment, decode, hold, writes.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/1ns
module phy_strap_latch_properties
(
   input wire logic               core_clk,
   input wire logic               srst,
   input wire logic [2:0]         mgmt_addr_strap,
   input wire logic [2:0]         ifmode_strap,
   input wire logic               iso_strap,
   input wire logic               speed_strap,
   input wire logic               duplex_strap,
   input wire logic               autoneg_en_strap,
   input wire logic               bcast_disable_strap,
   input wire logic               nand_tree_n_strap,
   input wire logic               ctrl_wr,
   input wire logic [15:0]        ctrl_wdata,
   input wire logic [11:0]        strap_pin_out,
   input wire logic [11:0]        strap_pin_oe,
   input wire logic [4:0]         mgmt_addr_value,
   input wire logic               bcast_addr_en,
   input wire strap_pkg::ifmode_t ifmode,
   input wire logic               ifmode_rsvd,
   input wire logic [15:0]        ctrl_reg,
   input wire logic               adv_speed_100,
   input wire logic               nand_tree_en,
   input wire logic               straps_valid
);
   // Pins are checked against captures on the edge valid is first seen
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (srst);
   chk_capture_time: assert property
      (!srst && $past(srst) |-> !straps_valid [*3] ##1 straps_valid)
      else $error("capture not on third edge after release");
   chk_addr_capture: assert property
      ($rose(straps_valid) |-> mgmt_addr_value[2:0] == mgmt_addr_strap)
      else $error("address low bits differ from pins");
   chk_addr_high_zero: assert property
      (mgmt_addr_value[4:3] == 2'h0)
      else $error("address high bits not zero");
   chk_bcast_capture: assert property
      ($rose(straps_valid) |-> bcast_addr_en == !bcast_disable_strap)
      else $error("broadcast enable differs from pin");
   chk_mode_decode: assert property
      ($rose(straps_valid) |->
         ifmode_rsvd == (ifmode_strap != 3'h0 && ifmode_strap != 3'h6) &&
         ifmode == ((ifmode_strap == 3'h0) ? strap_pkg::IFM_MII :
                    (ifmode_strap == 3'h6) ? strap_pkg::IFM_B2B :
                    strap_pkg::IFM_RSVD))
      else $error("interface mode decode wrong");
   chk_ctrl_capture: assert property
      ($rose(straps_valid) |-> adv_speed_100 == speed_strap &&
         ctrl_reg == {2'h0, speed_strap, autoneg_en_strap, 1'h0,
                      iso_strap, 1'h0, duplex_strap, 8'h00})
      else $error("control bits differ from pins");
   chk_nand_enable: assert property
      ($rose(straps_valid) |-> nand_tree_en == !nand_tree_n_strap)
      else $error("test mode enable wrong");
   chk_pins_drive: assert property
      (strap_pin_oe == {12{straps_valid}} &&
       (straps_valid || strap_pin_out == 12'h000))
      else $error("pins driven before capture");
   chk_ctrl_hold: assert property
      (straps_valid && !ctrl_wr |=> $stable(ctrl_reg))
      else $error("control moved without a write");
   chk_ctrl_write: assert property
      (straps_valid && ctrl_wr |=> ctrl_reg == $past(ctrl_wdata))
      else $error("control write not taken");
endmodule : phy_strap_latch_properties
bind phy_strap_latch phy_strap_latch_properties i_chk (.*);

// ==== dv/strap_board_model.sv ====
// Board side of the strap pins: weak pulls, or a MAC driving in reset.
// Assumes the bench says when the MAC drives; levels are static.
`timescale 1ns/1ns
module strap_board_model
(
   input  wire logic [0:0]  mac_drive,
   input  wire logic [11:0] mac_val,
   output logic      [11:0] pins
);
   // Undriven pins fall to pull levels, never keep the last MAC value
   assign pins = mac_drive ? mac_val : {3'h1, 3'h0, 6'h1d};
endmodule : strap_board_model

// ==== dv/phy_strap_latch_tb_top.sv ====
// Bench for the strap latch: one strap set per reset, then overrides.
// Assumes the board model and the bound checker are compiled with it.
`timescale 1ns/1ns
module phy_strap_latch_tb_top;
   logic               core_clk        = 1'h0;
   logic               srst            = 1'h1;
   logic               mac_drive       = 1'h0;
   logic [11:0]        mac_val         = 12'h000;
   logic [11:0]        func_pin_out    = 12'h000;
   logic               ctrl_wr         = 1'h0;
   logic [15:0]        ctrl_wdata      = 16'h0000;
   logic               bcast_off_wr    = 1'h0;
   logic               bcast_off_wdata = 1'h0;
   logic               adv_speed_wr    = 1'h0;
   logic               adv_speed_wdata = 1'h0;
   logic [11:0]        pins, strap_pin_out, strap_pin_oe;
   logic [4:0]         mgmt_addr_value;
   logic [15:0]        ctrl_reg;
   logic               bcast_addr_en, ifmode_rsvd, adv_speed_100;
   logic               nand_tree_en, straps_valid;
   strap_pkg::ifmode_t ifmode;
   int                 fail_count      = 0;
   int                 checks          = 0;

   strap_board_model i_strap_board_model (.mac_drive(mac_drive),
      .mac_val(mac_val), .pins(pins));
   phy_strap_latch i_phy_strap_latch (.mgmt_addr_strap(pins[11:9]),
      .ifmode_strap(pins[8:6]), .iso_strap(pins[5]), .speed_strap(pins[4]),
      .duplex_strap(pins[3]), .autoneg_en_strap(pins[2]),
      .bcast_disable_strap(pins[1]), .nand_tree_n_strap(pins[0]), .*);

   // 25 MHz core clock
   initial forever #20 core_clk = ~core_clk;

   task automatic finish_test;
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : finish_test

   task automatic check(input string what, input logic [15:0] seen,
                        input logic [15:0] exp);
      checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // Mode decode as {reserved, mode}
   function automatic logic [2:0] exp_mode(input logic [2:0] c);
      return (c == 3'h0) ? {1'h0, strap_pkg::IFM_MII} :
             (c == 3'h6) ? {1'h0, strap_pkg::IFM_B2B} :
             {1'h1, strap_pkg::IFM_RSVD};
   endfunction : exp_mode

   function automatic logic [15:0] exp_ctrl(input logic [11:0] v);
      return {2'h0, v[4], v[2], 1'h0, v[5], 1'h0, v[3], 8'h00};
   endfunction : exp_ctrl

   task automatic check_caps(input logic [11:0] v);
      check("addr", {11'h0, mgmt_addr_value}, {13'h0, v[11:9]});
      check("mode", {13'h0, ifmode_rsvd, ifmode}, {13'h0, exp_mode(v[8:6])});
      check("ctrl", ctrl_reg, exp_ctrl(v));
      check("flags", {13'h0, adv_speed_100, bcast_addr_en, nand_tree_en},
            {13'h0, v[4], ~v[1], ~v[0]});
      check("drive", {4'h0, strap_pin_out & strap_pin_oe},
            {4'h0, func_pin_out});
   endtask : check_caps

   // Writes held until capture must be refused; the wait is bounded
   task automatic run_reset(input logic drv, input logic [11:0] v);
      int n;
      @(posedge core_clk);
      srst         <= 1'h1;
      mac_drive    <= drv;
      mac_val      <= v;
      func_pin_out <= 12'($urandom);
      {ctrl_wr, bcast_off_wr, adv_speed_wr} <= 3'h7;
      {bcast_off_wdata, adv_speed_wdata}    <= 2'h2;
      ctrl_wdata   <= 16'($urandom);
      repeat (10) @(posedge core_clk);
      srst <= 1'h0;
      n = 0;
      #1;
      while (straps_valid !== 1'h1 && n < 8)
      begin
         check("rst_pins", {4'h0, strap_pin_oe | strap_pin_out},
               16'h0000);
         check("rst_ctrl", ctrl_reg, 16'h3100);
         check("rst_cfg", {7'h0, mgmt_addr_value, adv_speed_100,
               bcast_addr_en, nand_tree_en, straps_valid},
               {7'h0, 5'h01, 4'hc});
         @(posedge core_clk);
         #1 n++;
      end
      {ctrl_wr, bcast_off_wr, adv_speed_wr} <= 3'h0;
      check("valid_time", 16'(n), 16'h0003);
      if (straps_valid !== 1'h1)
         finish_test();
   endtask : run_reset

   initial
   begin
      logic [11:0] v;
      logic [15:0] w;
      logic [1:0]  ab;
      void'($urandom(32'h60d16e19));
      for (int it = 0; it < 10; it++)
      begin
         v = 12'($urandom);
         if (it < 8)
            v[8:6] = it[2:0];
         if (it == 9)
            v = 12'h21d;  // Pulls only: addr 1, MII, 100M full, autoneg
         run_reset(it != 9, v);
         check_caps(v);
         // Pins flip after capture; results must not follow
         @(posedge core_clk);
         mac_drive <= 1'h1;
         mac_val   <= ~v;
         repeat (4) @(posedge core_clk);
         check_caps(v);
         w  = 16'($urandom);
         ab = 2'($urandom);
         {ctrl_wr, bcast_off_wr, adv_speed_wr} <= 3'h7;
         {ctrl_wdata, bcast_off_wdata, adv_speed_wdata} <= {w, ab};
         @(posedge core_clk);
         ctrl_wdata <= ~w;  // Back to back: second write wins
         @(posedge core_clk);
         {ctrl_wr, bcast_off_wr, adv_speed_wr} <= 3'h0;
         #1 check("wr", ctrl_reg, ~w);
         check("wr_bits", {14'h0, bcast_addr_en, adv_speed_100},
               {14'h0, ~ab[1], ab[0]});
      end
      finish_test();
   end
endmodule : phy_strap_latch_tb_top
